/* hdl/msel_irq.sv */
// Interrupt status, register access and start-up channel selection of the master selector
`timescale 1ns/10ps
`include "msel_map.svh"
// ----------------------------------------------------------------
// What this block does
// - Status bit 0 follows the downstream interrupt input level.
// - Status bit 1 sets when downstream recovery completes.
// - Status bit 2 sets if bus busy at switch, unless recovery requested.
// - Status bit 3 sets in the losing master's copy on switch.
// - Status bit 6 reads 1 while own self-test request is set.
// - Status bit 7 reads 1 while other master's peer-test request is set.
// - All status bits read-only, reset to zero, bits 4 and 5 zero.
// - Reading does not clear input, self-test or peer-test flags.
// - Reading clears recovery, not-idle and lost flags at second SCL pulse.
// - Input flag persisting after a read raises the interrupt again.
// - Test interrupt goes away when its request bit is cleared.
// - Power-on reset loads all registers with defaults before bus traffic.
// - Variant one connects channel 0 right after reset.
// - Variant two connects channel 0 at the first STOP on channel 0.
// - Any STOP on channel 0 counts, addressed to us or not.
// - Channel 1 switch request connects channel 1 at its own STOP.
// - Variant three connects nothing after reset.
// - After any control write, control registers alone decide connection.
// - External reset low holds registers and slave machine at defaults.
// - Variant two after external reset waits for STOP, then channel 0.
// - Auto-increment write from mask register refuses a third data byte.
// - Auto-increment read wraps from the third register back to the first.
// - Each channel has its own status copy, read only by that channel.
// - Status register sits at pointer value binary 10.
// - Downstream interrupt pulls each unmasked upstream interrupt low.
// ----------------------------------------------------------------
module msel_irq
#(
    parameter logic [1:0] BUILD_VARIANT = `MSEL_VARIANT_1
)
(
    // Clock and reset
    input  wire logic                       clk_sys_in,
    input  wire logic                       rst_n_in,
    // Upstream I2C channels
    input  wire msel_pkg::msel_pins_t [1:0] up_pins_in,
    output logic [1:0]                      up_sda_out,
    output logic [1:0]                      up_sda_oe_out,
    input  wire logic [3:0]                 addr_pins_in,
    // Downstream side
    input  wire logic                       int_in_n_in,
    input  wire logic                       bus_busy_in,
    input  wire logic                       recovery_done_in,
    output logic                            conn_ch0_out,
    output logic                            conn_ch1_out,
    output logic                            recovery_req_out,
    // Interrupt outputs, open drain
    output logic                            channel0_irq_out,
    output logic                            channel0_irq_oe_out,
    output logic                            channel1_irq_out,
    output logic                            channel1_irq_oe_out
);
    import msel_pkg::*;

    msel_state_t s;
    msel_state_t n;
    logic [1:0]  rise;
    logic [1:0]  fall;
    logic [1:0]  start;
    logic [1:0]  stop;
    logic [1:0]  rd_clr;
    logic [1:0]  ctrl_wr;
    logic        dflt_fire;
    logic        app;
    logic        new_own;
    logic        new_on;

    // ----------------------------------------------------------------
    // Register read mux
    // ----------------------------------------------------------------
    function automatic logic [7:0] reg_read(input msel_state_t st, input logic c,
                                            input logic [1:0] p);
        logic [7:0] v;
        v = 8'h00;
        case (p)
            `MSEL_REG_MASK: v = {4'h0, st.ch[c].mask};
            `MSEL_REG_CTRL: v = {st.ch[c].ntest, st.ch[c].test, 1'b0, st.ch[c].recovery_flag,
                                 st.ch[~c].buson, st.ch[c].buson,
                                 c ? ~st.ch[0].mybus : st.ch[1].mybus, st.ch[c].mybus};
            // Own copy per channel, upper unused bits tied low
            `MSEL_REG_STAT: v = {st.ch[~c].ntest, st.ch[c].test, 2'b00, st.ch[c].sticky,
                                 ~st.sync2[`MSEL_SY_INT]};
            default:        v = 8'h00;
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        n = s;
        rise = 2'b00;
        fall = 2'b00;
        start = 2'b00;
        stop = 2'b00;
        rd_clr = 2'b00;
        ctrl_wr = 2'b00;
        n.rec_req = 1'b0;
        // Two stages on the upstream, interrupt and address pins before anything looks at them
        n.sync1 = {addr_pins_in, int_in_n_in, up_pins_in[1].sda, up_pins_in[1].scl,
                   up_pins_in[0].sda, up_pins_in[0].scl};
        n.sync2 = s.sync1;
        n.prev = s.sync2[3:0];
        for (int c = 0; c < 2; c++)
        begin
            rise[c]  = s.sync2[2*c] & ~s.prev[2*c];
            fall[c]  = ~s.sync2[2*c] & s.prev[2*c];
            start[c] = s.sync2[2*c] & s.prev[2*c] & s.prev[2*c+1] & ~s.sync2[2*c+1];
            stop[c]  = s.sync2[2*c] & s.prev[2*c] & ~s.prev[2*c+1] & s.sync2[2*c+1];
            if (rise[c])
            begin
                n.ch[c].shift = {s.ch[c].shift[6:0], s.sync2[2*c+1]};
                n.ch[c].bitcnt = 4'(s.ch[c].bitcnt + 4'h1);
            end
            if (start[c])
            begin
                n.ch[c].st = MSEL_ADDR;
                n.ch[c].bitcnt = 4'h0;
                n.ch[c].sda_oe = 1'b0;
            end
            else if (stop[c])
            begin
                n.ch[c].st = MSEL_IDLE;
                n.ch[c].sda_oe = 1'b0;
                n.ch[c].pend = 1'b0;
            end
            else
            begin
                case (s.ch[c].st)
                    MSEL_IDLE:
                        n.ch[c].sda_oe = 1'b0;
                    MSEL_ADDR:
                        if (fall[c] && s.ch[c].bitcnt == `MSEL_BYTE_BITS)
                        begin
                            if (s.ch[c].shift[7:1] == {`MSEL_ADDR_PREFIX,
                                                       s.sync2[8:`MSEL_SY_ADDR_LO]})
                            begin
                                n.ch[c].st = MSEL_ACK_A;
                                n.ch[c].rw = s.ch[c].shift[0];
                                n.ch[c].sda_oe = 1'b1;
                            end
                            else
                            begin
                                n.ch[c].st = MSEL_IDLE;
                            end
                        end
                    MSEL_ACK_A:
                        if (fall[c])
                        begin
                            n.ch[c].bitcnt = 4'h0;
                            if (s.ch[c].rw)
                            begin
                                n.ch[c].st = MSEL_RDATA;
                                n.ch[c].shift = reg_read(s, 1'(c), s.ch[c].ptr);
                                n.ch[c].sda_oe = ~n.ch[c].shift[7];
                            end
                            else
                            begin
                                n.ch[c].st = MSEL_PTR;
                                n.ch[c].sda_oe = 1'b0;
                            end
                        end
                    MSEL_PTR:
                        if (fall[c] && s.ch[c].bitcnt == `MSEL_BYTE_BITS)
                        begin
                            n.ch[c].ptr = s.ch[c].shift[1:0];
                            n.ch[c].ai = s.ch[c].shift[`MSEL_PTR_AI_BIT];
                            n.ch[c].st = MSEL_ACK_P;
                            n.ch[c].sda_oe = 1'b1;
                        end
                    MSEL_ACK_P, MSEL_ACK_W:
                        if (fall[c])
                        begin
                            n.ch[c].st = MSEL_WDATA;
                            n.ch[c].bitcnt = 4'h0;
                            n.ch[c].sda_oe = 1'b0;
                        end
                    MSEL_WDATA:
                        if (fall[c] && s.ch[c].bitcnt == `MSEL_BYTE_BITS)
                        begin
                            // Status and beyond are not writable: no acknowledge
                            if (s.ch[c].ptr > `MSEL_REG_CTRL)
                            begin
                                n.ch[c].st = MSEL_IDLE;
                            end
                            else
                            begin
                                n.ch[c].st = MSEL_ACK_W;
                                n.ch[c].sda_oe = 1'b1;
                                if (s.ch[c].ai)
                                begin
                                    n.ch[c].ptr = 2'(s.ch[c].ptr + 2'h1);
                                end
                                if (s.ch[c].ptr == `MSEL_REG_MASK)
                                begin
                                    n.ch[c].mask = s.ch[c].shift[3:0];
                                end
                                else
                                begin
                                    ctrl_wr[c] = 1'b1;
                                    n.ch[c].pend = 1'b1;
                                    n.ch[c].mybus = s.ch[c].shift[`MSEL_CTRL_MYBUS];
                                    n.ch[c].buson = s.ch[c].shift[`MSEL_CTRL_BUSON];
                                    n.ch[c].recovery_flag = s.ch[c].shift[`MSEL_CTRL_RECOVERY_FLAG];
                                    n.ch[c].test = s.ch[c].shift[`MSEL_CTRL_TEST];
                                    n.ch[c].ntest = s.ch[c].shift[`MSEL_CTRL_NTEST];
                                end
                            end
                        end
                    MSEL_RDATA:
                    begin
                        // Snapshot was taken at load, so the cleared flags still read out
                        if (rise[c] && s.ch[c].bitcnt == 4'h1 && s.ch[c].ptr == `MSEL_REG_STAT)
                        begin
                            rd_clr[c] = 1'b1;
                            n.ch[c].sticky = 3'h0;
                        end
                        if (fall[c])
                        begin
                            if (s.ch[c].bitcnt == `MSEL_BYTE_BITS)
                            begin
                                n.ch[c].st = MSEL_ACK_R;
                                n.ch[c].sda_oe = 1'b0;
                            end
                            else
                            begin
                                // Rise already shifted, so the next bit sits at the top
                                n.ch[c].sda_oe = ~s.ch[c].shift[7];
                            end
                        end
                    end
                    MSEL_ACK_R:
                        if (rise[c] && s.sync2[2*c+1])
                        begin
                            n.ch[c].st = MSEL_IDLE;
                        end
                        else if (fall[c])
                        begin
                            if (s.ch[c].ai)
                            begin
                                n.ch[c].ptr = (s.ch[c].ptr == `MSEL_REG_STAT) ? `MSEL_REG_MASK
                                              : 2'(s.ch[c].ptr + 2'h1);
                            end
                            n.ch[c].st = MSEL_RDATA;
                            n.ch[c].bitcnt = 4'h0;
                            n.ch[c].shift = reg_read(s, 1'(c), n.ch[c].ptr);
                            n.ch[c].sda_oe = ~n.ch[c].shift[7];
                        end
                    default:
                    begin
                        n.ch[c].st = MSEL_IDLE;
                        n.ch[c].sda_oe = 1'b0;
                    end
                endcase
            end
        end

        // Start-up default waits for any STOP on channel 0, unless overridden
        dflt_fire = s.dflt_wait & stop[0] & ~(|ctrl_wr);
        if (|ctrl_wr)
        begin
            n.dflt_wait = 1'b0;
        end
        if (dflt_fire)
        begin
            n.dflt_wait = 1'b0;
            n.ch[0].buson = ~n.ch[1].buson;
        end

        // Connection changes only at the writing master's STOP or at the start-up default STOP on channel 0
        app = dflt_fire | (stop[0] & s.ch[0].pend) | (stop[1] & s.ch[1].pend);
        new_own = n.ch[0].mybus ^ n.ch[1].mybus;
        new_on = n.ch[0].buson ^ n.ch[1].buson;
        if (app)
        begin
            n.owner = new_own;
            n.on = new_on;
            if (new_on && (new_own != s.owner || !s.on))
            begin
                if (s.on)
                begin
                    n.ch[s.owner].sticky[2] = 1'b1;
                end
                if (n.ch[new_own].recovery_flag)
                begin
                    n.rec_req = 1'b1;
                end
                else if (bus_busy_in)
                begin
                    n.ch[new_own].sticky[1] = 1'b1;
                end
            end
        end
        // Sets come after the read clear, so a coinciding event survives
        if (recovery_done_in && s.on)
        begin
            n.ch[s.owner].sticky[0] = 1'b1;
        end

        // Level interrupt: a still-active input keeps the line low after a read
        for (int c = 0; c < 2; c++)
        begin
            n.ch[c].irq_oe = (|({s.ch[c].sticky, ~s.sync2[`MSEL_SY_INT]} & ~s.ch[c].mask))
                             | s.ch[c].test | s.ch[1-c].ntest;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            // All defaults loaded while reset is low
            s <= '0;
            s.sync1 <= '1;
            s.sync2 <= '1;
            s.prev <= '1;
            s.ch[0].st <= MSEL_IDLE;
            s.ch[1].st <= MSEL_IDLE;
            s.ch[0].buson <= (BUILD_VARIANT == `MSEL_VARIANT_1);
            s.on <= (BUILD_VARIANT == `MSEL_VARIANT_1);
            s.dflt_wait <= (BUILD_VARIANT == `MSEL_VARIANT_2);
        end
        else
        begin
            s <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign up_sda_out = 2'b00;
    assign up_sda_oe_out = {s.ch[1].sda_oe, s.ch[0].sda_oe};
    assign conn_ch0_out = s.on & ~s.owner;
    assign conn_ch1_out = s.on & s.owner;
    assign recovery_req_out = s.rec_req;
    assign channel0_irq_out = 1'b0;
    assign channel1_irq_out = 1'b0;
    assign channel0_irq_oe_out = s.ch[0].irq_oe;
    assign channel1_irq_oe_out = s.ch[1].irq_oe;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_default_stop;
        dflt_fire && !s.ch[1].buson;
    endsequence
    sequence s_ch0_on;
        conn_ch0_out && !conn_ch1_out;
    endsequence

    a_input_irq_drive: assert property ((!s.sync2[`MSEL_SY_INT] && !s.ch[0].mask[0])
        |=> channel0_irq_oe_out) else $error("input irq not driven");
    a_self_test_irq: assert property (s.ch[1].test |=> channel1_irq_oe_out)
        else $error("self test irq missing");
    a_peer_test_irq: assert property (s.ch[1].ntest |=> channel0_irq_oe_out)
        else $error("peer test irq missing");
    a_irq_release: assert property ((!s.ch[0].test && !s.ch[1].ntest && s.ch[0].sticky == 3'h0
        && s.sync2[`MSEL_SY_INT]) |=> !channel0_irq_oe_out)
        else $error("irq not released");
    a_read_clear_flags: assert property ((rd_clr[0] && !app && !recovery_done_in)
        |=> s.ch[0].sticky == 3'h0) else $error("status flags not cleared");
    a_lost_on_switch: assert property ((app && s.on && n.on && n.owner != s.owner)
        |=> s.ch[$past(s.owner)].sticky[2]) else $error("lost flag missing");
    a_default_connect: assert property (s_default_stop |=> s_ch0_on)
        else $error("default connection missing");
    a_wait_before_stop: assert property (s.dflt_wait |-> !s.on)
        else $error("connected before stop");
    a_no_third_ack: assert property ((s.ch[0].st == MSEL_WDATA && fall[0] && !start[0]
        && !stop[0] && s.ch[0].bitcnt == 4'h8 && s.ch[0].ptr == 2'h2)
        |=> !up_sda_oe_out[0] ##1 !up_sda_oe_out[0]) else $error("third byte acked");
    a_read_wrap: assert property ((s.ch[0].st == MSEL_ACK_R && fall[0] && !start[0] && !stop[0]
        && s.ch[0].ai && s.ch[0].ptr == 2'h2) |=> s.ch[0].ptr == 2'h0)
        else $error("read pointer not wrapped");
endmodule

/* hdl/msel_map.svh */
// Register offsets, field positions, reset values and codes of the master selector
`ifndef MSEL_MAP_SVH
`define MSEL_MAP_SVH

// ----------------------------------------------------------------
// Register pointer values
// ----------------------------------------------------------------
`define MSEL_REG_MASK      2'h0
`define MSEL_REG_CTRL      2'h1
`define MSEL_REG_STAT      2'h2
`define MSEL_PTR_AI_BIT    4

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define MSEL_CTRL_MYBUS    0
`define MSEL_CTRL_BUSON    2
`define MSEL_CTRL_RECOVERY_FLAG  4
`define MSEL_CTRL_TEST     6
`define MSEL_CTRL_NTEST    7

// ----------------------------------------------------------------
// Status register fields and reset value
// ----------------------------------------------------------------
`define MSEL_STAT_INPUT    0
`define MSEL_STAT_RECOVERY 1
`define MSEL_STAT_NOTIDLE  2
`define MSEL_STAT_LOST     3
`define MSEL_STAT_SELF     6
`define MSEL_STAT_PEER     7
`define MSEL_STAT_RST      8'h00

// ----------------------------------------------------------------
// Slave address, byte length, build variants
// ----------------------------------------------------------------
`define MSEL_ADDR_PREFIX   3'h7
`define MSEL_BYTE_BITS     4'h8
`define MSEL_VARIANT_1     2'h1
`define MSEL_VARIANT_2     2'h2
`define MSEL_VARIANT_3     2'h3

// ----------------------------------------------------------------
// Synchroniser bit positions
// ----------------------------------------------------------------
`define MSEL_SY_INT        4
`define MSEL_SY_ADDR_LO    5

`endif

/* hdl/msel_pkg.sv */
// Types shared by the master selector status and start-up logic
package msel_pkg;

    // ----------------------------------------------------------------
    // Upstream pins and slave states
    // ----------------------------------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
    } msel_pins_t;

    typedef enum logic [8:0] {
        MSEL_IDLE  = 9'h001,
        MSEL_ADDR  = 9'h002,
        MSEL_ACK_A = 9'h004,
        MSEL_PTR   = 9'h008,
        MSEL_ACK_P = 9'h010,
        MSEL_WDATA = 9'h020,
        MSEL_ACK_W = 9'h040,
        MSEL_RDATA = 9'h080,
        MSEL_ACK_R = 9'h100
    } msel_slv_state_t;

    // ----------------------------------------------------------------
    // Per-channel and whole-block state
    // ----------------------------------------------------------------
    typedef struct packed {
        msel_slv_state_t st;
        logic [3:0]      bitcnt;
        logic [7:0]      shift;
        logic            rw;
        logic [1:0]      ptr;
        logic            ai;
        logic            sda_oe;
        logic            mybus;
        logic            buson;
        logic            recovery_flag;
        logic            test;
        logic            ntest;
        logic [3:0]      mask;
        logic [2:0]      sticky;
        logic            pend;
        logic            irq_oe;
    } msel_chan_t;

    typedef struct packed {
        logic [8:0]       sync1;
        logic [8:0]       sync2;
        logic [3:0]       prev;
        msel_chan_t [1:0] ch;
        logic             owner;
        logic             on;
        logic             dflt_wait;
        logic             rec_req;
    } msel_state_t;

endpackage

/* sim/msel_master.sv */
// Upstream I2C master model for one channel of the master selector
`timescale 1ns/10ps
module msel_master
(
    // Clock and device answer
    input  wire logic            clk_sys_in,
    input  wire logic            sda_oe_in,
    // Pins and read results
    output msel_pkg::msel_pins_t pins_out,
    output logic [7:0]           rd_data_out,
    output logic                 rd_valid_out
);
    import msel_pkg::*;
    logic scl = 1'b1;
    logic sda_drv = 1'b1;
    // Pull-up on SDA: a released line reads high, never the old value
    wire  sda_bus = sda_drv & ~sda_oe_in;
    assign pins_out = '{scl: scl, sda: sda_bus};
    initial
    begin
        rd_data_out = 8'h00;
        rd_valid_out = 1'b0;
    end
    // SCL phases of 4 clocks each, 320 ns period; stands high between frames
    task automatic half();
        repeat (4) @(negedge clk_sys_in);
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_drv = b;
        half();
        scl = 1'b1;
        half();
        s = sda_bus;
        scl = 1'b0;
    endtask
    task automatic start();
        sda_drv = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b0;
        half();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask
    task automatic xfer(input logic [7:0] b, input logic mack, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r[i]);
        bit_io(mack, a);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
        logic [7:0] r;
        start();
        xfer({a, 1'b0}, 1'b1, r);
        xfer(p, 1'b1, r);
        xfer(d, 1'b1, r);
        stop();
    endtask
    // Each byte read is published for one clock
    task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n);
        logic [7:0] r;
        start();
        xfer({a, 1'b0}, 1'b1, r);
        xfer(p, 1'b1, r);
        start();
        xfer({a, 1'b1}, 1'b1, r);
        for (int k = 0; k < n; k++)
        begin
            xfer(8'hFF, k == n - 1, r);
            rd_data_out = r;
            rd_valid_out = 1'b1;
            @(negedge clk_sys_in);
            rd_valid_out = 1'b0;
        end
        stop();
    endtask
endmodule

/* sim/tb_msel_irq.sv */
// Self-checking bench for the master selector status and start-up logic
`timescale 1ns/10ps
`include "msel_map.svh"
module tb_msel_irq;
    import msel_pkg::*;
    logic             clk_sys_in;
    logic             rst_n_in;
    logic             int_in_n_in;
    logic             bus_busy_in;
    logic             recovery_done_in;
    logic [3:0]       addr_pins_in;
    msel_pins_t [1:0] up_pins_in;
    logic [1:0]       up_sda_oe_out;
    logic             conn_ch0_out;
    logic             conn_ch1_out;
    logic             ch0_oe;
    logic             ch1_oe;
    logic [7:0]       rd_data [2];
    logic [1:0]       rd_valid;
    logic [7:0]       expq [$];
    logic [6:0]       dev;
    logic [3:2]       vc0;
    logic             rec_req;
    int               n_rec = 0;
    int               num_errors = 0;
    int               n_compared = 0;
    int               seed;
    msel_irq i_msel_irq (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .up_pins_in(up_pins_in), .up_sda_out(), .up_sda_oe_out(up_sda_oe_out),
        .addr_pins_in(addr_pins_in), .int_in_n_in(int_in_n_in), .bus_busy_in(bus_busy_in),
        .recovery_done_in(recovery_done_in), .conn_ch0_out(conn_ch0_out),
        .conn_ch1_out(conn_ch1_out), .recovery_req_out(rec_req), .channel0_irq_out(),
        .channel0_irq_oe_out(ch0_oe), .channel1_irq_out(), .channel1_irq_oe_out(ch1_oe));
    for (genvar g = 0; g < 2; g++)
    begin : g_up
        msel_master i_msel_master (.clk_sys_in(clk_sys_in), .sda_oe_in(up_sda_oe_out[g]),
            .pins_out(up_pins_in[g]), .rd_data_out(rd_data[g]), .rd_valid_out(rd_valid[g]));
    end
    // Listeners in the other two build variants, connection only
    for (genvar v = 2; v < 4; v++)
    begin : g_var
        msel_irq #(.BUILD_VARIANT(2'(v))) i_msel_irq (.clk_sys_in(clk_sys_in),
            .rst_n_in(rst_n_in), .up_pins_in(up_pins_in), .up_sda_out(), .up_sda_oe_out(),
            .addr_pins_in(addr_pins_in), .int_in_n_in(int_in_n_in), .bus_busy_in(bus_busy_in),
            .recovery_done_in(recovery_done_in), .conn_ch0_out(vc0[v]), .conn_ch1_out(),
            .recovery_req_out(), .channel0_irq_out(), .channel0_irq_oe_out(),
            .channel1_irq_out(), .channel1_irq_oe_out());
    end
    initial
    begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("compared=%0d errors=%0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Pins {conn1, conn0, irq1, irq0} after sync and register delay
    task automatic pins(input logic [3:0] e);
        repeat (5) @(negedge clk_sys_in);
        chk({4'h0, conn_ch1_out, conn_ch0_out, ch1_oe, ch0_oe}, {4'h0, e});
    endtask
    task automatic st(input int ch, input logic [7:0] e);
        expq.push_back(e);
        if (ch == 0)
            g_up[0].i_msel_master.rd(dev, {6'h0, `MSEL_REG_STAT}, 1);
        else
            g_up[1].i_msel_master.rd(dev, {6'h0, `MSEL_REG_STAT}, 1);
    endtask
    task automatic wc(input int ch, input logic [7:0] d);
        if (ch == 0)
            g_up[0].i_msel_master.wr(dev, {6'h0, `MSEL_REG_CTRL}, d);
        else
            g_up[1].i_msel_master.wr(dev, {6'h0, `MSEL_REG_CTRL}, d);
    endtask
    // Result watcher: each published byte takes the oldest note
    always @(posedge clk_sys_in)
        if (rd_valid !== 2'b00)
        begin
            if (expq.size() == 0)
                num_errors++;
            else
                chk(rd_valid[0] ? rd_data[0] : rd_data[1], expq.pop_front());
        end
    // Recovery request pulses seen on the main instance
    always @(posedge clk_sys_in)
        if (rec_req === 1'b1)
            n_rec++;
    initial
    begin
        seed = 32'h0a4c;
        rst_n_in = 1'b0;
        int_in_n_in = 1'b1;
        bus_busy_in = 1'b0;
        recovery_done_in = 1'b0;
        addr_pins_in = 4'($random(seed));
        dev = {`MSEL_ADDR_PREFIX, addr_pins_in};
        repeat (4) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        pins(4'b0100);
        chk({6'h0, vc0}, 8'h00);
        expq = '{8'h00, 8'h04, 8'h00, 8'h00};
        g_up[0].i_msel_master.rd(dev, 8'h10, 4);
        int_in_n_in = 1'b0;
        pins(4'b0111);
        chk({6'h0, vc0}, 8'h01);
        st(1, 8'h01);
        st(1, 8'h01);
        int_in_n_in = 1'b1;
        pins(4'b0100);
        wc(0, 8'h44);
        st(0, 8'h40);
        wc(1, 8'h80);
        st(0, 8'hC0);
        pins(4'b0101);
        chk({6'h0, vc0}, 8'h03);
        wc(0, 8'h04);
        wc(1, 8'h00);
        g_up[0].i_msel_master.wr(dev, {6'h0, `MSEL_REG_STAT}, 8'hFF);
        st(0, 8'h00);
        @(negedge clk_sys_in);
        recovery_done_in = 1'b1;
        @(negedge clk_sys_in);
        recovery_done_in = 1'b0;
        st(0, 8'h02);
        st(0, 8'h00);
        bus_busy_in = 1'b1;
        wc(1, 8'h01);
        bus_busy_in = 1'b0;
        pins(4'b1011);
        st(0, 8'h08);
        st(1, 8'h04);
        pins(4'b1000);
        bus_busy_in = 1'b1;
        wc(0, 8'h15);
        bus_busy_in = 1'b0;
        pins(4'b0110);
        chk(8'(n_rec), 8'h01);
        rst_n_in = 1'b0;
        pins(4'b0100);
        chk({6'h0, vc0}, 8'h00);
        rst_n_in = 1'b1;
        st(0, 8'h00);
        chk({6'h0, vc0}, 8'h01);
        for (int k = 0; k < 50 && expq.size() > 0; k++)
            @(posedge clk_sys_in);
        if (expq.size() > 0)
            num_errors++;
        results();
    end
endmodule
